// [src/bcsd_top.sv]
// Bridge command support decode: tracks address phases on the primary and
// secondary bus, decides claim or ignore per command, vets commands the
// bridge wants to master, and flags Type-1 writes that become special cycles.
// Assumes bus pins arrive from outside the mclk domain, while address hit
// and master request inputs come from decode logic on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "bcsd_cfg.svh"

module bcsd_top #(
  parameter int AD_W = 16
) (
  // Clock, reset, enable
  input  wire logic            mclk,
  input  wire logic            rstn,
  input  wire logic            ce,
  // Primary bus pins
  input  wire logic            p_frame_n,
  input  wire logic [3:0]      p_cbe,
  input  wire logic [AD_W-1:0] p_ad,
  // Primary decode results
  input  wire logic            p_addr_hit,
  input  wire logic            p_sc_bus_hit,
  // Secondary bus pins
  input  wire logic            s_frame_n,
  input  wire logic [3:0]      s_cbe,
  input  wire logic [AD_W-1:0] s_ad,
  // Secondary decode results
  input  wire logic            s_addr_hit,
  input  wire logic            s_sc_bus_hit,
  // Master requests
  input  wire logic            p_mst_req,
  input  wire logic [3:0]      p_mst_cmd,
  input  wire logic            p_mst_type1,
  input  wire logic            s_mst_req,
  input  wire logic [3:0]      s_mst_cmd,
  input  wire logic            s_mst_type1,
  // Primary verdicts
  output logic                 p_claim,
  output logic                 p_ignore,
  output logic [3:0]           p_cmd,
  output logic                 p_dac,
  output logic                 p_mst_ok,
  output logic                 p_mst_deny,
  output logic                 p_sc_gen,
  // Secondary verdicts
  output logic                 s_claim,
  output logic                 s_ignore,
  output logic [3:0]           s_cmd,
  output logic                 s_dac,
  output logic                 s_mst_ok,
  output logic                 s_mst_deny,
  output logic                 s_sc_gen
);

  localparam int NB = 2;

  // Index 0 is the primary bus, index 1 the secondary bus
  logic [NB-1:0]       frame_pin_n;
  logic [3:0]          cbe_pin   [NB];
  logic [AD_W-1:0]     ad_pin    [NB];
  logic [NB-1:0]       hit_in;
  logic [NB-1:0]       sc_hit_in;
  logic [NB-1:0]       mreq_in;
  logic [3:0]          mcmd_in   [NB];
  logic [NB-1:0]       mtype1_in;

  logic [NB-1:0]       claim_reg;
  logic [NB-1:0]       ignore_reg;
  logic [3:0]          cmd_reg   [NB];
  logic [NB-1:0]       dac_reg;
  logic [NB-1:0]       mok_reg;
  logic [NB-1:0]       mdeny_reg;
  logic [NB-1:0]       sc_seen;
  logic [NB-1:0]       sc_gen_reg;

  assign frame_pin_n = {s_frame_n, p_frame_n};
  assign cbe_pin[0]  = p_cbe;
  assign cbe_pin[1]  = s_cbe;
  assign ad_pin[0]   = p_ad;
  assign ad_pin[1]   = s_ad;
  assign hit_in      = {s_addr_hit, p_addr_hit};
  assign sc_hit_in   = {s_sc_bus_hit, p_sc_bus_hit};
  assign mreq_in     = {s_mst_req, p_mst_req};
  assign mcmd_in[0]  = p_mst_cmd;
  assign mcmd_in[1]  = s_mst_cmd;
  assign mtype1_in   = {s_mst_type1, p_mst_type1};

  for (genvar b = 0; b < NB; b++) begin : g_bus
    logic                   frame_s1;
    logic                   frame_s2;
    logic                   frame_s3;
    logic                   frame_ok_n;
    logic [3:0]             cbe_s1;
    logic [3:0]             cbe_s2;
    logic [3:0]             cbe_s3;
    logic [3:0]             cbe_ok;
    logic [AD_W-1:0]        ad_s1;
    logic [AD_W-1:0]        ad_s2;
    logic [AD_W-1:0]        ad_s3;
    logic [AD_W-1:0]        ad_ok;
    bcsd_pkg::bcsd_state_t  state_reg;
    logic                   decide;
    logic                   in_dac;
    logic                   type1;
    logic                   tgt_claim;
    logic                   mst_ok;

    // Three stage capture of the pins; stage 1 feeds stage 2 only
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        frame_s1 <= `BCSD_RST_FRAME_N;
        frame_s2 <= `BCSD_RST_FRAME_N;
        frame_s3 <= `BCSD_RST_FRAME_N;
        cbe_s1   <= `BCSD_RST_CBE;
        cbe_s2   <= `BCSD_RST_CBE;
        cbe_s3   <= `BCSD_RST_CBE;
        ad_s1    <= '0;
        ad_s2    <= '0;
        ad_s3    <= '0;
      end else if (ce) begin
        frame_s1 <= frame_pin_n[b];
        frame_s2 <= frame_s1;
        frame_s3 <= frame_s2;
        cbe_s1   <= cbe_pin[b];
        cbe_s2   <= cbe_s1;
        cbe_s3   <= cbe_s2;
        ad_s1    <= ad_pin[b];
        ad_s2    <= ad_s1;
        ad_s3    <= ad_s2;
      end
    end

    // Accept a bit only once stages 2 and 3 agree; filters metastable splits
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        frame_ok_n <= `BCSD_RST_FRAME_N;
        cbe_ok     <= `BCSD_RST_CBE;
        ad_ok      <= '0;
      end else if (ce) begin
        if (frame_s2 == frame_s3) begin
          frame_ok_n <= frame_s3;
        end
        cbe_ok <= (cbe_s3 & ~(cbe_s2 ^ cbe_s3)) | (cbe_ok & (cbe_s2 ^ cbe_s3));
        ad_ok  <= (ad_s3 & ~(ad_s2 ^ ad_s3)) | (ad_ok & (ad_s2 ^ ad_s3));
      end
    end

    // Decision on the first cycle of frame asserted after idle, or in DAC2 once the code is no longer DAC
    assign in_dac = (state_reg == bcsd_pkg::BCSD_ST_DAC2);
    assign decide = ((state_reg == bcsd_pkg::BCSD_ST_IDLE) || in_dac) && !frame_ok_n
                    && (cbe_ok != bcsd_pkg::BCSD_DAC);
    assign type1  = (ad_ok[`BCSD_CFG_TYPE_MSB:`BCSD_CFG_TYPE_LSB] == `BCSD_CFG_TYPE1);

    always_ff @(posedge mclk) begin
      if (!rstn) begin
        state_reg <= bcsd_pkg::BCSD_ST_IDLE;
      end else if (ce) begin
        unique case (state_reg)
          bcsd_pkg::BCSD_ST_IDLE: begin
            if (!frame_ok_n) begin
              // Dual address: the real command follows one cycle later
              state_reg <= (cbe_ok == bcsd_pkg::BCSD_DAC) ? bcsd_pkg::BCSD_ST_DAC2
                                                          : bcsd_pkg::BCSD_ST_BUSY;
            end
          end
          bcsd_pkg::BCSD_ST_DAC2: begin
            // Agreed code lingers a cycle; wait for the second phase command
            if (frame_ok_n) begin
              state_reg <= bcsd_pkg::BCSD_ST_IDLE;
            end else if (cbe_ok != bcsd_pkg::BCSD_DAC) begin
              state_reg <= bcsd_pkg::BCSD_ST_BUSY;
            end
          end
          bcsd_pkg::BCSD_ST_BUSY: begin
            if (frame_ok_n) begin
              state_reg <= bcsd_pkg::BCSD_ST_IDLE;
            end
          end
          default: begin
            state_reg <= bcsd_pkg::BCSD_ST_IDLE;
          end
        endcase
      end
    end

    bcsd_cmd_filter #(
      .PRIMARY (b == 0)
    ) u_filter (
      .tgt_cmd   (cbe_ok),
      .tgt_type1 (type1),
      .tgt_dac   (in_dac),
      .tgt_hit   (hit_in[b]),
      .mst_cmd   (mcmd_in[b]),
      .mst_type1 (mtype1_in[b]),
      .tgt_claim (tgt_claim),
      .mst_ok    (mst_ok)
    );

    // Claim or ignore verdict, one pulse per address phase
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        claim_reg[b]  <= `BCSD_RST_PULSE;
        ignore_reg[b] <= `BCSD_RST_PULSE;
        cmd_reg[b]    <= `BCSD_RST_CBE;
        dac_reg[b]    <= `BCSD_RST_PULSE;
      end else if (ce) begin
        claim_reg[b]  <= decide & tgt_claim;
        ignore_reg[b] <= decide & ~tgt_claim;
        if (decide) begin
          cmd_reg[b] <= cbe_ok;
          dac_reg[b] <= in_dac;
        end
      end
    end

    // Master vetting, answered one cycle after each request
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        mok_reg[b]   <= `BCSD_RST_PULSE;
        mdeny_reg[b] <= `BCSD_RST_PULSE;
      end else if (ce) begin
        mok_reg[b]   <= mreq_in[b] & mst_ok;
        mdeny_reg[b] <= mreq_in[b] & ~mst_ok;
      end
    end

    // Claimed Type-1 write carrying the special cycle address for a far bus
    assign sc_seen[b] = decide && tgt_claim && type1 && sc_hit_in[b]
                        && (cbe_ok == bcsd_pkg::BCSD_CFG_WR)
                        && (ad_ok[`BCSD_CFG_DEV_MSB:`BCSD_CFG_DEV_LSB] == `BCSD_SC_DEV)
                        && (ad_ok[`BCSD_CFG_FUN_MSB:`BCSD_CFG_FUN_LSB] == `BCSD_SC_FUN)
                        && (ad_ok[`BCSD_CFG_REG_MSB:`BCSD_CFG_REG_LSB] == `BCSD_SC_REG);
  end

  // Special cycle is produced on the bus opposite the one that asked
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sc_gen_reg <= '0;
    end else if (ce) begin
      sc_gen_reg <= {sc_seen[0], sc_seen[1]};
    end
  end

  assign p_claim    = claim_reg[0];
  assign p_ignore   = ignore_reg[0];
  assign p_cmd      = cmd_reg[0];
  assign p_dac      = dac_reg[0];
  assign p_mst_ok   = mok_reg[0];
  assign p_mst_deny = mdeny_reg[0];
  assign p_sc_gen   = sc_gen_reg[0];
  assign s_claim    = claim_reg[1];
  assign s_ignore   = ignore_reg[1];
  assign s_cmd      = cmd_reg[1];
  assign s_dac      = dac_reg[1];
  assign s_mst_ok   = mok_reg[1];
  assign s_mst_deny = mdeny_reg[1];
  assign s_sc_gen   = sc_gen_reg[1];

endmodule

`default_nettype wire

// [src/bcsd_cfg.svh]
// Constants of the bridge command support decode: pin field positions,
// special cycle encoding of a Type-1 configuration address, reset values.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef BCSD_CFG_SVH
`define BCSD_CFG_SVH

// Configuration address fields on the low address/data lines
`define BCSD_CFG_TYPE_MSB    1
`define BCSD_CFG_TYPE_LSB    0
`define BCSD_CFG_TYPE1       2'h1
`define BCSD_CFG_DEV_MSB     15
`define BCSD_CFG_DEV_LSB     11
`define BCSD_CFG_FUN_MSB     10
`define BCSD_CFG_FUN_LSB     8
`define BCSD_CFG_REG_MSB     7
`define BCSD_CFG_REG_LSB     2

// Type-1 address that asks for a special cycle on the addressed bus
`define BCSD_SC_DEV          5'h1F
`define BCSD_SC_FUN          3'h7
`define BCSD_SC_REG          6'h00

// Reset values
`define BCSD_RST_FRAME_N     1'b1
`define BCSD_RST_CBE         4'hF
`define BCSD_RST_PULSE       1'b0

`endif

// [src/bcsd_pkg.sv]
// Types of the bridge command support decode: bus command codes and the
// address phase tracker states. No dependencies.
package bcsd_pkg;

  typedef enum logic [3:0] {
    BCSD_INT_ACK   = 4'h0,
    BCSD_SPECIAL   = 4'h1,
    BCSD_IO_RD     = 4'h2,
    BCSD_IO_WR     = 4'h3,
    BCSD_RSVD_4    = 4'h4,
    BCSD_RSVD_5    = 4'h5,
    BCSD_MEM_RD    = 4'h6,
    BCSD_MEM_WR    = 4'h7,
    BCSD_RSVD_8    = 4'h8,
    BCSD_RSVD_9    = 4'h9,
    BCSD_CFG_RD    = 4'hA,
    BCSD_CFG_WR    = 4'hB,
    BCSD_MEM_RDM   = 4'hC,
    BCSD_DAC       = 4'hD,
    BCSD_MEM_RDL   = 4'hE,
    BCSD_MEM_WRI   = 4'hF
  } bcsd_cmd_t;

  typedef enum logic [2:0] {
    BCSD_ST_IDLE = 3'b001,
    BCSD_ST_DAC2 = 3'b010,
    BCSD_ST_BUSY = 3'b100
  } bcsd_state_t;

endpackage

// [src/bcsd_cmd_filter.sv]
// Per-bus command support table: which commands this bus side may claim
// as a target and which it may issue as a master.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none

module bcsd_cmd_filter #(
  parameter bit PRIMARY = 1'b1
) (
  // Target side, command seen in an address phase
  input  wire logic [3:0] tgt_cmd,
  input  wire logic       tgt_type1,
  input  wire logic       tgt_dac,
  input  wire logic       tgt_hit,
  // Master side, command the bridge wants to issue
  input  wire logic [3:0] mst_cmd,
  input  wire logic       mst_type1,
  // Verdicts
  output logic            tgt_claim,
  output logic            mst_ok
);

  logic tgt_supported;

  always_comb begin
    tgt_supported = 1'b0;
    if (tgt_dac) begin
      // Only memory commands may follow a dual address phase
      unique case (bcsd_pkg::bcsd_cmd_t'(tgt_cmd))
        bcsd_pkg::BCSD_MEM_WR,
        bcsd_pkg::BCSD_MEM_WRI,
        bcsd_pkg::BCSD_MEM_RD,
        bcsd_pkg::BCSD_MEM_RDL,
        bcsd_pkg::BCSD_MEM_RDM: tgt_supported = 1'b1;
        default:                tgt_supported = 1'b0;
      endcase
    end else begin
      unique case (bcsd_pkg::bcsd_cmd_t'(tgt_cmd))
        bcsd_pkg::BCSD_INT_ACK: tgt_supported = 1'b0;
        bcsd_pkg::BCSD_SPECIAL: tgt_supported = 1'b0;
        bcsd_pkg::BCSD_RSVD_4,
        bcsd_pkg::BCSD_RSVD_5,
        bcsd_pkg::BCSD_RSVD_8,
        bcsd_pkg::BCSD_RSVD_9:  tgt_supported = 1'b0;
        bcsd_pkg::BCSD_CFG_RD:  tgt_supported = PRIMARY;
        bcsd_pkg::BCSD_CFG_WR:  tgt_supported = PRIMARY | tgt_type1;
        // A DAC first phase is resolved by its second phase
        bcsd_pkg::BCSD_DAC:     tgt_supported = 1'b0;
        default:                tgt_supported = 1'b1;
      endcase
    end
    // Positive decode only: no hit, no claim
    tgt_claim = tgt_supported & tgt_hit;
  end

  always_comb begin
    unique case (bcsd_pkg::bcsd_cmd_t'(mst_cmd))
      bcsd_pkg::BCSD_INT_ACK: mst_ok = 1'b0;
      bcsd_pkg::BCSD_RSVD_4,
      bcsd_pkg::BCSD_RSVD_5,
      bcsd_pkg::BCSD_RSVD_8,
      bcsd_pkg::BCSD_RSVD_9:  mst_ok = 1'b0;
      bcsd_pkg::BCSD_CFG_RD:  mst_ok = ~PRIMARY;
      bcsd_pkg::BCSD_CFG_WR:  mst_ok = ~PRIMARY | mst_type1;
      default:                mst_ok = 1'b1;
    endcase
  end

endmodule

`default_nettype wire

// [dv/bcsd_pci_init.sv]
// PCI initiator model driving FRAME, C/BE and AD of one bus.
// Assumes the bench calls phase() just after a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module bcsd_pci_init (
  // Clock
  input  wire logic        mclk,
  // Bus pins
  output logic             frame_n,
  output logic [3:0]       cbe,
  output logic [15:0]      ad
);
  initial begin
    frame_n = 1'b1;
    cbe = 4'hF;
    ad = 16'h0000;
  end

  task automatic phase(input logic [3:0] cmd, input logic dac, input logic [15:0] a);
    frame_n = 1'b0;
    cbe = dac ? 4'hD : cmd;
    ad = a;
    // Each pin value stands at least two cycles so the three stage capture sees it
    repeat (2) @(posedge mclk);
    #1 cbe = cmd;
    repeat (6) @(posedge mclk);
    #1 frame_n = 1'b1;
    // Released lines must not keep the last value
    cbe = ~cbe;
    ad = ~ad;
    repeat (4) @(posedge mclk);
    #1;
  endtask
endmodule
`default_nettype wire

// [dv/bcsd_checker.sv]
// Assertion checker bound to the ports of bcsd_top.
// Assumes ce stays high, else the fixed latencies stretch.
`timescale 1ns/1ps
`default_nettype none
module bcsd_checker (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Target verdicts
  input  wire logic       p_claim,
  input  wire logic       p_ignore,
  input  wire logic [3:0] p_cmd,
  input  wire logic       p_dac,
  input  wire logic       p_addr_hit,
  input  wire logic       s_claim,
  input  wire logic [3:0] s_cmd,
  input  wire logic       s_sc_gen,
  // Master vetting
  input  wire logic       p_mst_req,
  input  wire logic [3:0] p_mst_cmd,
  input  wire logic       p_mst_type1,
  input  wire logic       p_mst_ok,
  input  wire logic       p_mst_deny,
  input  wire logic       s_mst_req,
  input  wire logic [3:0] s_mst_cmd,
  input  wire logic       s_mst_ok,
  input  wire logic       s_mst_deny
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_sc_src;
    p_claim && p_cmd == 4'hB;
  endsequence

  a_claim_excl: assert property (!(p_claim && p_ignore))
    else $error("claim and ignore together");
  a_p_no_intack: assert property (p_claim |-> p_cmd != 4'h0)
    else $error("interrupt acknowledge claimed");
  a_p_no_rsvd: assert property (p_claim |-> !(p_cmd inside {4'h4, 4'h5, 4'h8, 4'h9}))
    else $error("reserved code claimed");
  a_s_no_special: assert property (s_claim |-> !(s_cmd inside {4'h0, 4'h1}))
    else $error("special cycle claimed");
  a_s_no_cfgrd: assert property (s_claim |-> s_cmd != 4'hA)
    else $error("config read claimed on secondary");
  a_dac_mem: assert property (p_claim && p_dac |-> p_cmd inside {4'h6, 4'h7, 4'hC, 4'hE, 4'hF})
    else $error("non-memory command claimed after dual address");
  a_hit_needed: assert property (p_claim |-> $past(p_addr_hit))
    else $error("claim without address hit");
  a_pri_type0: assert property (p_mst_req && p_mst_cmd == 4'hB && !p_mst_type1 |=> p_mst_deny && !p_mst_ok)
    else $error("Type-0 write allowed on primary");
  a_pri_cfgrd: assert property (p_mst_req && p_mst_cmd == 4'hA |=> p_mst_deny)
    else $error("config read allowed on primary");
  a_sec_rsvd: assert property (s_mst_req && s_mst_cmd inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9} |=> s_mst_deny)
    else $error("forbidden code allowed on secondary");
  a_sec_cfgwr: assert property (s_mst_req && s_mst_cmd == 4'hB |=> s_mst_ok && !s_mst_deny)
    else $error("config write refused on secondary");
  a_sc_pair: assert property (s_sc_gen |-> s_sc_src)
    else $error("special cycle without Type-1 write claim");
endmodule
bind bcsd_top bcsd_checker u_chk (.mclk, .rstn, .p_claim, .p_ignore, .p_cmd, .p_dac, .p_addr_hit, .s_claim,
  .s_cmd, .s_sc_gen, .p_mst_req, .p_mst_cmd, .p_mst_type1, .p_mst_ok, .p_mst_deny, .s_mst_req, .s_mst_cmd,
  .s_mst_ok, .s_mst_deny);
`default_nettype wire

// [dv/test_bridge_command_support_decode.sv]
// Self-checking bench for bcsd_top with one initiator model per bus.
// Assumes AD_W at its default of 16 and ce held high.
`timescale 1ns/1ps
`default_nettype none
module test_bridge_command_support_decode;
  logic       mclk, rstn, ce, p_frame_n, s_frame_n;
  logic [3:0] p_cbe, s_cbe, p_mst_cmd, s_mst_cmd, p_cmd, s_cmd;
  logic [15:0] p_ad, s_ad;
  logic       p_addr_hit, p_sc_bus_hit, s_addr_hit, s_sc_bus_hit;
  logic       p_mst_req, p_mst_type1, s_mst_req, s_mst_type1;
  logic       p_claim, p_ignore, p_dac, p_mst_ok, p_mst_deny, p_sc_gen;
  logic       s_claim, s_ignore, s_dac, s_mst_ok, s_mst_deny, s_sc_gen;
  int         fail_count = 0;
  int         tests_run = 0;

  bcsd_top dut (.mclk, .rstn, .ce, .p_frame_n, .p_cbe, .p_ad, .p_addr_hit, .p_sc_bus_hit, .s_frame_n,
    .s_cbe, .s_ad, .s_addr_hit, .s_sc_bus_hit, .p_mst_req, .p_mst_cmd, .p_mst_type1, .s_mst_req, .s_mst_cmd,
    .s_mst_type1, .p_claim, .p_ignore, .p_cmd, .p_dac, .p_mst_ok, .p_mst_deny, .p_sc_gen, .s_claim,
    .s_ignore, .s_cmd, .s_dac, .s_mst_ok, .s_mst_deny, .s_sc_gen);
  bcsd_pci_init u_pri (.mclk, .frame_n(p_frame_n), .cbe(p_cbe), .ad(p_ad));
  bcsd_pci_init u_sec (.mclk, .frame_n(s_frame_n), .cbe(s_cbe), .ad(s_ad));

  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic tok(input bit b, input logic [3:0] c, input logic t1);
    return c inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF} || (!b && c == 4'hA) || (c == 4'hB && (!b || t1));
  endfunction

  function automatic logic mok(input bit b, input logic [3:0] c, input logic t1);
    return !(c inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9}) && (b || (c != 4'hA && (c != 4'hB || t1)));
  endfunction

  // One address phase on bus b; ec/es are the expected claim and special cycle
  task automatic tgt(input bit b, input logic [3:0] c, input bit d, input logic [15:0] a,
                     input logic hit, input logic sc, input logic ec, input logic es);
    logic [7:0] v;
    v = 8'h00;
    p_addr_hit = hit;
    s_addr_hit = hit;
    p_sc_bus_hit = sc;
    s_sc_bus_hit = sc;
    fork
      if (b) u_sec.phase(c, d, a);
      else u_pri.phase(c, d, a);
      repeat (12) begin
        @(posedge mclk);
        #1;
        if (v[7:6] == 2'b00)
          v = b ? {s_claim, s_ignore, s_dac, s_cmd, p_sc_gen} : {p_claim, p_ignore, p_dac, p_cmd, s_sc_gen};
      end
    join
    chk("claim", v[7], ec);
    chk("ignore", v[6], !ec);
    chk("dac", v[5], d);
    chk("cmd", v[4:1], c);
    chk("sc_gen", v[0], es);
  endtask

  task automatic test_table;
    for (int d = 0; d < 2; d++) begin
      for (int b = 0; b < 2; b++) begin
        for (int c = 0; c < 16; c++) begin
          if (c != 13)
            tgt(b[0], c[3:0], d[0], 16'h0001, 1'b1, 1'b0,
                d ? c inside {6, 7, 12, 14, 15} : tok(b[0], c[3:0], 1'b1), 1'b0);
        end
      end
    end
    tgt(1'b1, 4'hB, 1'b0, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b0);
    tgt(1'b0, 4'hB, 1'b0, 16'h0000, 1'b1, 1'b0, 1'b1, 1'b0);
    tgt(1'b0, 4'h7, 1'b0, 16'h0001, 1'b0, 1'b0, 1'b0, 1'b0);
    tgt(1'b1, 4'hE, 1'b0, 16'h0001, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test_table done");
  endtask

  task automatic test_special;
    tgt(1'b0, 4'hB, 1'b0, 16'hFF01, 1'b1, 1'b1, 1'b1, 1'b1);
    tgt(1'b1, 4'hB, 1'b0, 16'hFF01, 1'b1, 1'b1, 1'b1, 1'b1);
    tgt(1'b0, 4'hB, 1'b0, 16'hFF01, 1'b1, 1'b0, 1'b1, 1'b0);
    tgt(1'b1, 4'hB, 1'b0, 16'hFF05, 1'b1, 1'b1, 1'b1, 1'b0);
    $display("test_special done");
  endtask

  // Requests back to back on both buses at once
  task automatic test_master;
    p_mst_req = 1'b1;
    s_mst_req = 1'b1;
    for (int i = 0; i < 32; i++) begin
      p_mst_cmd = i[3:0];
      s_mst_cmd = i[3:0];
      p_mst_type1 = i[4];
      s_mst_type1 = i[4];
      @(posedge mclk);
      #1;
      chk("p_mst_ok", p_mst_ok, mok(1'b0, i[3:0], i[4]));
      chk("p_mst_deny", p_mst_deny, !mok(1'b0, i[3:0], i[4]));
      chk("s_mst_ok", s_mst_ok, mok(1'b1, i[3:0], i[4]));
      chk("s_mst_deny", s_mst_deny, !mok(1'b1, i[3:0], i[4]));
    end
    p_mst_req = 1'b0;
    s_mst_req = 1'b0;
    $display("test_master done");
  endtask

  task automatic end_sim;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Run takes about 21 us; a hang is cut well after that
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    {p_addr_hit, p_sc_bus_hit, s_addr_hit, s_sc_bus_hit} = 4'h0;
    {p_mst_req, p_mst_type1, s_mst_req, s_mst_type1} = 4'h0;
    p_mst_cmd = 4'h0;
    s_mst_cmd = 4'h0;
    repeat (5) @(posedge mclk);
    #1 rstn = 1'b1;
    test_table();
    test_special();
    test_master();
    end_sim();
  end
endmodule
`default_nettype wire
